// ===== rtl/cmc_mode_ctrl.sv
// Purpose: CAN transceiver mode control, wake detect, tx gating
// Assumes: inputs synchronous to clk_sys; bus level 0 = dominant
// Notes:   fail_safe overrides the requested mode
//
// How it works
// R1 - reset puts the transceiver in off mode
// R2 - off mode ignores bus wake activity, no wake event
// R3 - mode is taken from the written mode control bits
// R4 - normal mode only allowed in normal or stop system mode
// R5 - normal mode drives bus from transmit input, low is dominant
// R6 - controller keeps transmit input recessive until enable delay ends
// R7 - dominant before delay end dropped; next dominant after recessive sent
// R8 - normal and receive-only modes copy bus level to receive output
// R9 - receive-only mode keeps driver off, reception continues
// R10 - receive-only accepted only in normal or stop system mode
// R11 - wake mode allowed in stop, sleep, restart, normal system mode
// R12 - fail-safe forces wake-capable mode
// R13 - detected wake holds receive output low until mode changes; code also releases it on stop or fail-safe entry
// R14 - software selects normal mode before talking after a wake
// R15 - wake needs two dominant phases inside min/max window
// R16 - dominant phases separated by recessive phase inside window
// R17 - mode bits keep wake code; rearm on mode change, stop, fail-safe
// R18 - enable delay and wake limits are cycle-count parameters
// R19 - any phase outside the window restarts the wake search
`include "cmc_map.svh"
module cmc_mode_ctrl
  import cmc_pkg::*;
#(
  parameter logic [15:0] EN_DELAY_CYC = `CMC_EN_DELAY_CYC,
  parameter logic [15:0] WAKE_MIN_CYC = `CMC_WAKE_MIN_CYC,
  parameter logic [15:0] WAKE_MAX_CYC = `CMC_WAKE_MAX_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [1:0] mode_req,
  input  wire logic       mode_req_valid,
  input  wire cmc_sys_t   sys_mode,
  input  wire logic       fail_safe,
  input  wire logic       can_tx_input,
  input  wire logic       bus_level,
  input  wire logic       tx_ready,
  output logic            bus_drive_dom,
  output logic            bus_drive_valid,
  output logic            can_rx_out,
  output logic [1:0]      mode_status,
  output logic            wake_event,
  output logic            enable_done
);
  // ************************************************************
  // mode selection
  // ************************************************************
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic       mode_chg;
  logic       sys_stop_or_fs;
  logic       sys_stop_or_fs_q;

  function automatic logic mode_ok(input logic [1:0] m, input cmc_sys_t s);
    case (m)
      `CMC_MODE_NORMAL: mode_ok = (s == CMC_SYS_NORMAL) ||
                                  (s == CMC_SYS_STOP); // [R4]
      `CMC_MODE_RXONLY: mode_ok = (s == CMC_SYS_NORMAL) ||
                                  (s == CMC_SYS_STOP); // [R10]
      `CMC_MODE_WAKE:   mode_ok = (s != CMC_SYS_INIT); // [R11]
      default:          mode_ok = 1'b1;
    endcase
  endfunction

  always_comb begin
    mode_d = mode_q;
    if (fail_safe) begin
      mode_d = `CMC_MODE_WAKE; // [R12]
    end else if (mode_req_valid && mode_ok(mode_req, sys_mode)) begin
      mode_d = mode_req; // [R3]
    end else if (!mode_ok(mode_q, sys_mode)) begin
      mode_d = `CMC_MODE_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= `CMC_MODE_OFF; // [R1]
    end else begin
      mode_q <= mode_d;
    end
  end

  assign mode_chg       = (mode_d != mode_q);
  assign sys_stop_or_fs = fail_safe || (sys_mode == CMC_SYS_STOP);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sys_stop_or_fs_q <= 1'b0;
    end else begin
      sys_stop_or_fs_q <= sys_stop_or_fs;
    end
  end

  // ************************************************************
  // enabling delay and transmit gate
  // ************************************************************
  logic [15:0] en_cnt_q;
  logic        en_done_q;
  logic        armed_q;
  logic        tx_gate;

  always_ff @(posedge clk_sys) begin
    if (reset || mode_q != `CMC_MODE_NORMAL) begin
      en_cnt_q  <= 16'h0000;
      en_done_q <= 1'b0;
    end else if (!en_done_q) begin
      en_cnt_q  <= en_cnt_q + 16'h0001;
      en_done_q <= (en_cnt_q + 16'h0001 >= EN_DELAY_CYC); // [R18]
    end
  end

  // dominant only after a recessive seen once delay is done
  always_ff @(posedge clk_sys) begin
    if (reset || !en_done_q || mode_q != `CMC_MODE_NORMAL) begin
      armed_q <= 1'b0; // [R7]
    end else if (can_tx_input) begin
      armed_q <= 1'b1; // [R6] [R7]
    end
  end

  assign tx_gate = (mode_q == `CMC_MODE_NORMAL) && armed_q; // [R9]

  // ************************************************************
  // two-entry buffer toward the bus driver
  // ************************************************************
  logic [1:0] buf_data_q;
  logic [1:0] buf_cnt_q;
  logic       in_bit;
  logic       push;
  logic       pop;

  assign in_bit = tx_gate ? ~can_tx_input : 1'b0; // [R5]
  assign push   = (buf_cnt_q != 2'h2);
  assign pop    = bus_drive_valid && tx_ready;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      buf_cnt_q  <= 2'h0;
      buf_data_q <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          buf_data_q[buf_cnt_q[0]] <= in_bit;
          buf_cnt_q <= buf_cnt_q + 2'h1;
        end
        2'b01: begin
          buf_data_q[0] <= buf_data_q[1];
          buf_cnt_q <= buf_cnt_q - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_q == 2'h1) begin
            buf_data_q[0] <= in_bit;
          end else begin
            buf_data_q[0] <= buf_data_q[1];
            buf_data_q[1] <= in_bit;
          end
        end
        default: begin
          buf_cnt_q <= buf_cnt_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_drive_valid <= 1'b0;
      bus_drive_dom   <= 1'b0;
    end else begin
      bus_drive_valid <= (buf_cnt_q != 2'h0) && !pop ||
                         (buf_cnt_q == 2'h2);
      bus_drive_dom   <= buf_data_q[pop ? 1'b1 : 1'b0] &&
                         (mode_q == `CMC_MODE_NORMAL); // [R9]
    end
  end

  // ************************************************************
  // wake pattern detector
  // ************************************************************
  cmc_wake_t   wst_q;
  logic [15:0] ph_cnt_q;
  logic        bus_q;
  logic        edge_s;
  logic        in_win;
  logic        too_long;
  logic        wake_on;

  assign wake_on  = (mode_q == `CMC_MODE_WAKE) && !mode_chg &&
                    !(sys_stop_or_fs && !sys_stop_or_fs_q);
  assign edge_s   = (bus_level != bus_q);
  assign in_win   = (ph_cnt_q > WAKE_MIN_CYC) &&
                    (ph_cnt_q < WAKE_MAX_CYC); // [R15] [R16]
  assign too_long = (ph_cnt_q >= WAKE_MAX_CYC);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_q    <= 1'b1;
      ph_cnt_q <= 16'h0000;
    end else begin
      bus_q    <= bus_level;
      ph_cnt_q <= edge_s ? 16'h0001 :
                  (too_long ? ph_cnt_q : ph_cnt_q + 16'h0001);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !wake_on) begin
      wst_q <= CMC_W_IDLE; // [R2] [R17]
    end else begin
      case (wst_q)
        CMC_W_IDLE: if (edge_s && !bus_level) wst_q <= CMC_W_DOM1;
        CMC_W_DOM1: if (edge_s) begin
          wst_q <= in_win ? CMC_W_REC : CMC_W_IDLE; // [R15] [R19]
        end else if (too_long) begin
          wst_q <= CMC_W_IDLE; // [R19]
        end
        CMC_W_REC: if (edge_s) begin
          wst_q <= in_win ? CMC_W_DOM2 : CMC_W_IDLE; // [R16] [R19]
        end else if (too_long) begin
          wst_q <= CMC_W_IDLE; // [R19]
        end
        CMC_W_DOM2: if (edge_s) begin
          wst_q <= in_win ? CMC_W_DONE : CMC_W_IDLE; // [R15] [R19]
        end else if (too_long) begin
          wst_q <= CMC_W_IDLE; // [R19]
        end
        CMC_W_DONE: wst_q <= CMC_W_DONE; // [R13]
        default:    wst_q <= CMC_W_IDLE;
      endcase
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      can_rx_out  <= 1'b1;
      mode_status <= `CMC_MODE_OFF;
      wake_event  <= 1'b0;
      enable_done <= 1'b0;
    end else begin
      mode_status <= mode_q; // [R17]
      enable_done <= en_done_q;
      wake_event  <= (wst_q == CMC_W_DONE); // [R2]
      if (mode_q == `CMC_MODE_NORMAL || mode_q == `CMC_MODE_RXONLY) begin
        can_rx_out <= bus_level; // [R8] [R9]
      end else if (mode_q == `CMC_MODE_WAKE) begin
        can_rx_out <= (wst_q != CMC_W_DONE); // [R13] [R14]
      end else begin
        can_rx_out <= 1'b1;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_off_no_wake: assert property ( // [R2]
    mode_q == `CMC_MODE_OFF |=> !wake_event)
    else $error("wake reported in off mode");
  a_fs_forces_wake: assert property ( // [R12]
    fail_safe |=> mode_q == `CMC_MODE_WAKE)
    else $error("fail-safe did not force wake mode");
  a_norm_sys_ok: assert property ( // [R4]
    mode_q == `CMC_MODE_NORMAL |->
      $past(sys_mode == CMC_SYS_NORMAL || sys_mode == CMC_SYS_STOP))
    else $error("normal mode in wrong system mode");
  a_rxonly_no_tx: assert property ( // [R9]
    mode_q == `CMC_MODE_RXONLY |=> !bus_drive_dom)
    else $error("driver active in receive-only");
  a_early_dom_blk: assert property ( // [R7]
    !en_done_q |-> !armed_q)
    else $error("transmit armed before enable delay");
  a_rx_follows: assert property ( // [R8]
    mode_q == `CMC_MODE_RXONLY && $stable(mode_q)
      |=> can_rx_out == $past(bus_level))
    else $error("rx output does not follow bus");
  a_wake_rx_low: assert property ( // [R13]
    wst_q == CMC_W_DONE && mode_q == `CMC_MODE_WAKE |=> !can_rx_out)
    else $error("rx not low after wake");
  a_mode_reset: assert property ( // [R1]
    $past(reset) |-> mode_q == `CMC_MODE_OFF)
    else $error("mode not off after reset");

  // main scenarios reached
  c_wake_seen: cover property (wst_q == CMC_W_DONE);
  c_tx_dom: cover property (bus_drive_dom);
  c_buf_full: cover property (buf_cnt_q == 2'h2);
  c_early_dom: cover property (!armed_q && mode_q == `CMC_MODE_NORMAL &&
    !can_tx_input);
  c_fs_wake: cover property (fail_safe && mode_q == `CMC_MODE_WAKE);
endmodule

// ===== pkg/cmc_map.svh
// Purpose: constants of the CAN transceiver mode control
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   counts are defaults for module parameters
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_CLK_MHZ        10
`define CMC_EN_DELAY_CYC   16'h00C8
`define CMC_WAKE_MIN_CYC   16'h0032
`define CMC_WAKE_MAX_CYC   16'h01F4
`define CMC_MODE_OFF       2'h0
`define CMC_MODE_WAKE      2'h1
`define CMC_MODE_RXONLY    2'h2
`define CMC_MODE_NORMAL    2'h3
`endif

// ===== pkg/cmc_pkg.sv
// Purpose: types of the CAN transceiver mode control
// Assumes: nothing
// Notes:   system mode and wake detector states
package cmc_pkg;
  typedef enum logic [4:0] {
    CMC_SYS_INIT    = 5'h01,
    CMC_SYS_NORMAL  = 5'h02,
    CMC_SYS_STOP    = 5'h04,
    CMC_SYS_SLEEP   = 5'h08,
    CMC_SYS_RESTART = 5'h10
  } cmc_sys_t;
  typedef enum logic [4:0] {
    CMC_W_IDLE = 5'h01,
    CMC_W_DOM1 = 5'h02,
    CMC_W_REC  = 5'h04,
    CMC_W_DOM2 = 5'h08,
    CMC_W_DONE = 5'h10
  } cmc_wake_t;
endpackage

// ===== tb/cmc_bus_peer.sv
// Purpose: far side model: CAN bus with driver echo and wake patterns
// Assumes: one clock, bus level 0 = dominant
// Notes:   ext_lvl and slow are steered by the bench, dom_cnt is read by it
module cmc_bus_peer (
  input  wire logic clk_sys,
  input  wire logic bus_drive_dom,
  input  wire logic bus_drive_valid,
  output logic      bus_level,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_q   = 1'b0;
  logic ext_lvl = 1'b1;
  logic slow    = 1'b0;
  logic pat_on  = 1'b0;
  int   dom_cnt = 0;
  int   cyc     = 0;
  // stalls every other cycle when slow
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    tx_ready <= !slow || cyc[0];
  end
  // accepted driver bits reach the bus
  always @(posedge clk_sys) begin
    if (bus_drive_valid && tx_ready) begin
      drv_q <= bus_drive_dom;
      if (bus_drive_dom) dom_cnt <= dom_cnt + 1;
    end
  end
  // recessive unless driven, injected or a wake pattern runs
  assign bus_level = pat_on ? 1'b0 : (!drv_q && ext_lvl);
  // *****************************************
  // wake pattern: dominant, recessive, dominant, long idle
  // *****************************************
  task automatic bus_wake_pattern(input int d1, input int r, input int d2);
    pat_on = 1'b1;
    repeat (d1) @(negedge clk_sys);
    pat_on = 1'b0;
    repeat (r) @(negedge clk_sys);
    pat_on = 1'b1;
    repeat (d2) @(negedge clk_sys);
    pat_on = 1'b0;
    repeat (12) @(negedge clk_sys);
  endtask
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench of the CAN transceiver mode control
// Assumes: short counts: delay 4, wake limits 3 and 10, window 4..9 cycles
// Notes:   expected modes come from an integer model of the rules
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cmc_pkg::*;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] mode_req = 2'h0;
  logic       mode_req_valid = 1'b0;
  cmc_sys_t   sys_mode = CMC_SYS_INIT;
  logic       fail_safe = 1'b0;
  logic       can_tx_input = 1'b1;
  logic       bus_level, tx_ready, bus_drive_dom, bus_drive_valid;
  logic       can_rx_out, wake_event, enable_done;
  logic [1:0] mode_status;
  int         n_errors = 0;
  int         num_checks = 0;
  int         seed = 71;
  int         s, m, exp_mode, d0;
  cmc_sys_t   sys_tab [5] = '{CMC_SYS_INIT, CMC_SYS_NORMAL, CMC_SYS_STOP,
                              CMC_SYS_SLEEP, CMC_SYS_RESTART};
  cmc_mode_ctrl #(.EN_DELAY_CYC(16'h0004), .WAKE_MIN_CYC(16'h0003),
    .WAKE_MAX_CYC(16'h000A)) u_cmc_mode_ctrl (
    .clk_sys(clk_sys), .reset(reset), .mode_req(mode_req),
    .mode_req_valid(mode_req_valid), .sys_mode(sys_mode),
    .fail_safe(fail_safe), .can_tx_input(can_tx_input),
    .bus_level(bus_level), .tx_ready(tx_ready),
    .bus_drive_dom(bus_drive_dom), .bus_drive_valid(bus_drive_valid),
    .can_rx_out(can_rx_out), .mode_status(mode_status),
    .wake_event(wake_event), .enable_done(enable_done));
  cmc_bus_peer u_peer (.clk_sys(clk_sys), .bus_drive_dom(bus_drive_dom),
    .bus_drive_valid(bus_drive_valid), .bus_level(bus_level),
    .tx_ready(tx_ready));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // *****************************************
  // model and helpers
  // *****************************************
  function automatic int allowed(input int md, input int sy);
    if (md == 1) return (sy != 0) ? 1 : 0;
    if (md >= 2) return (sy == 1 || sy == 2) ? md : 0;
    return 0;
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic req(input int md);
    @(negedge clk_sys);
    mode_req = md[1:0];
    mode_req_valid = 1'b1;
    @(negedge clk_sys);
    mode_req_valid = 1'b0;
  endtask
  task automatic await(input int k, input logic [1:0] v, input string nm);
    logic [1:0] g;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      g = k == 0 ? mode_status : k == 1 ? {1'b0, can_rx_out} :
          k == 2 ? {1'b0, wake_event} : {1'b0, enable_done};
      if (g === v) break;
    end
    `CHK(nm, v, g)
    if (g !== v) test_done();
  endtask
  initial begin
    repeat (20000) @(negedge clk_sys);
    n_errors++;
    test_done();
  end
  // *****************************************
  // main sequence
  // *****************************************
  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    `CHK("mode", 2'h0, mode_status)
    `CHK("rx", 1'b1, can_rx_out)
    u_peer.bus_wake_pattern(5, 5, 5);
    `CHK("wake_off", 1'b0, wake_event)
    tend("reset_off");
    for (int i = 0; i < 40; i++) begin
      s = $unsigned($random(seed)) % 5;
      m = $unsigned($random(seed)) % 4;
      sys_mode = sys_tab[s];
      req(0);
      req(m);
      exp_mode = allowed(m, s);
      repeat (2) @(negedge clk_sys);
      `CHK("mode", exp_mode[1:0], mode_status)
    end
    tend("mode_table");
    sys_mode = CMC_SYS_NORMAL;
    req(0);
    @(negedge clk_sys);
    req(3);
    `CHK("en_early", 1'b0, enable_done)
    can_tx_input = 1'b0; // early dominant on purpose
    @(negedge clk_sys);
    can_tx_input = 1'b1;
    await(3, 2'h1, "enable");
    `CHK("early_dom", 1'b1, u_peer.dom_cnt == 0)
    u_peer.slow = 1'b1;
    can_tx_input = 1'b0;
    await(1, 2'h0, "rx_dom");
    `CHK("dom_sent", 1'b1, u_peer.dom_cnt > 0)
    can_tx_input = 1'b1;
    await(1, 2'h1, "rx_rec");
    tend("normal");
    req(2);
    d0 = u_peer.dom_cnt;
    can_tx_input = 1'b0;
    u_peer.ext_lvl = 1'b0;
    await(1, 2'h0, "rx_only");
    repeat (8) @(negedge clk_sys);
    `CHK("no_drive", 1'b1, u_peer.dom_cnt == d0)
    u_peer.ext_lvl = 1'b1;
    can_tx_input = 1'b1;
    await(1, 2'h1, "rx_only_rec");
    tend("rx_only");
    sys_mode = CMC_SYS_STOP;
    req(1);
    u_peer.bus_wake_pattern(3, 5, 5);
    `CHK("wake_short", 1'b0, wake_event)
    u_peer.bus_wake_pattern(5, 10, 5);
    `CHK("wake_gap", 1'b0, wake_event)
    u_peer.bus_wake_pattern(5, 5, 5);
    await(2, 2'h1, "wake");
    `CHK("rx_wake", 1'b0, can_rx_out)
    `CHK("mode_wake", 2'h1, mode_status)
    req(3); // back to normal before talking
    await(1, 2'h1, "rx_after");
    req(1);
    `CHK("rearm_clr", 1'b0, wake_event)
    u_peer.bus_wake_pattern(5, 5, 5);
    await(2, 2'h1, "rearm");
    sys_mode = CMC_SYS_NORMAL;
    @(negedge clk_sys);
    sys_mode = CMC_SYS_STOP;
    repeat (3) @(negedge clk_sys);
    `CHK("rearm_stop", 1'b0, wake_event)
    `CHK("rx_rearm", 1'b1, can_rx_out)
    tend("wake");
    req(0);
    fail_safe = 1'b1;
    await(0, 2'h1, "fail_safe");
    fail_safe = 1'b0;
    tend("fail_safe");
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    `CHK("mode_rst", 2'h0, mode_status)
    `CHK("rx_rst", 1'b1, can_rx_out)
    @(negedge clk_sys);
    `CHK("mode_rel", 2'h0, mode_status)
    tend("reset_mid");
    test_done();
  end
endmodule
